/* File: rtl/enable_map_pkg.sv */
// Package with register map, field layout and defaults for the enable pin mapping bank
package enable_map_pkg;

    // ==================================================
    // Register offsets (register index; byte address is four times the index)
    localparam logic [7:0] pin_one_ldo_map_index = 8'h2f;
    localparam logic [7:0] pin_one_converter_map_index = 8'h30;
    localparam logic [7:0] pin_two_ldo_map_index = 8'h31;
    localparam logic [7:0] pin_two_converter_map_index = 8'h32;
    localparam int index_shift = 2;

    // ==================================================
    // Field layout
    localparam int map_width = 8;
    localparam int ldo_count = 10;
    localparam int buck_count = 4;
    localparam int converter_ldo_lsb = 0;
    localparam int converter_ldo_msb = 1;
    localparam int converter_buck_lsb = 2;
    localparam int converter_buck_msb = 5;
    localparam logic [7:0] converter_writable_mask = 8'h3f;

    // ==================================================
    // Default option set, used as power-on values when no programmed copy is given
    localparam logic [7:0] pin_one_ldo_map_reset = 8'h01;
    localparam logic [7:0] pin_one_converter_map_reset = 8'h04;
    localparam logic [7:0] pin_two_ldo_map_reset = 8'h18;
    localparam logic [7:0] pin_two_converter_map_reset = 8'h00;

    // ==================================================
    // Bus answer
    localparam logic [31:0] read_zero = 32'h0000_0000;

    // Register selected by an access
    typedef enum {
        sel_none,
        sel_one_ldo,
        sel_one_converter,
        sel_two_ldo,
        sel_two_converter
    } map_sel_t;

endpackage : enable_map_pkg

/* File: rtl/pin_enable_combine.sv */
`timescale 1ns/1ps
// Combines mapped enable pin levels with other enable sources per regulator
module pin_enable_combine
    import enable_map_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable_pin_one,
    input wire logic enable_pin_two,
    input wire logic [7:0] pin_one_ldo_map,
    input wire logic [7:0] pin_one_converter_map,
    input wire logic [7:0] pin_two_ldo_map,
    input wire logic [7:0] pin_two_converter_map,
    input wire logic [ldo_count-1:0] ldo_other_enable,
    input wire logic [buck_count-1:0] buck_other_enable,
    output logic [ldo_count-1:0] ldo_enable,
    output logic [buck_count-1:0] buck_enable
);

    logic [ldo_count-1:0] next_ldo_enable;
    logic [buck_count-1:0] next_buck_enable;

    // Per-regulator OR of pin requests and other sources
    always_comb begin
        next_ldo_enable = ldo_other_enable
            | ({pin_one_converter_map[converter_ldo_msb:converter_ldo_lsb],
                pin_one_ldo_map} & {ldo_count{enable_pin_one}})
            | ({pin_two_converter_map[converter_ldo_msb:converter_ldo_lsb],
                pin_two_ldo_map} & {ldo_count{enable_pin_two}}); // RL8
        next_buck_enable = buck_other_enable
            | (pin_one_converter_map[converter_buck_msb:converter_buck_lsb]
               & {buck_count{enable_pin_one}})
            | (pin_two_converter_map[converter_buck_msb:converter_buck_lsb]
               & {buck_count{enable_pin_two}}); // RL8
    end

    // Registered enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ldo_enable <= '0;
            buck_enable <= '0;
        end else begin
            ldo_enable <= next_ldo_enable;
            buck_enable <= next_buck_enable;
        end
    end

endmodule : pin_enable_combine

/* File: rtl/enable_pin_regulator_map.sv */
// Chosen here: register access over APB.
`timescale 1ns/1ps
// APB register bank mapping two enable pins onto regulators
// Summary of operation
// RL1 - Pin one low-dropout map at 2Fh
// RL2 - Pin one converter map at 30h
// RL3 - Pin two low-dropout map at 31h
// RL4 - Pin two converter map at 32h
// RL5 - Converter map bits 7:6 read zero
// RL6 - Power-on reset loads package defaults; first otp_load then captures programmed values
// RL7 - Writable bits read back last write
// RL8 - Mapped pin level ORed into enable
module enable_pin_regulator_map
    import enable_map_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic [7:0] otp_pin_one_ldo_map,
    input wire logic [7:0] otp_pin_one_converter_map,
    input wire logic [7:0] otp_pin_two_ldo_map,
    input wire logic [7:0] otp_pin_two_converter_map,
    input wire logic otp_load,
    input wire logic enable_pin_one,
    input wire logic enable_pin_two,
    input wire logic [ldo_count-1:0] ldo_other_enable,
    input wire logic [buck_count-1:0] buck_other_enable,
    output logic [ldo_count-1:0] ldo_enable,
    output logic [buck_count-1:0] buck_enable
);

    // ==================================================
    // Storage
    logic [7:0] pin_one_ldo_map;
    logic [7:0] pin_one_converter_map;
    logic [7:0] pin_two_ldo_map;
    logic [7:0] pin_two_converter_map;
    logic load_pending;
    map_sel_t sel;
    logic access;
    logic wr_lane;

    // Decode a byte address to a register
    function automatic map_sel_t decode(input logic [11:0] addr);
        if (addr[index_shift-1:0] != 2'b00) begin
            return sel_none;
        end
        unique case (addr[11:index_shift])
            {2'b00, pin_one_ldo_map_index}: return sel_one_ldo; // RL1
            {2'b00, pin_one_converter_map_index}: return sel_one_converter; // RL2
            {2'b00, pin_two_ldo_map_index}: return sel_two_ldo; // RL3
            {2'b00, pin_two_converter_map_index}: return sel_two_converter; // RL4
            default: return sel_none;
        endcase
    endfunction : decode

    // ==================================================
    // Bus decode, zero wait states
    assign sel = decode(paddr);
    assign access = psel && penable;
    assign wr_lane = access && pwrite && pstrb[0];
    assign pready = 1'b1;
    assign pslverr = access && (sel == sel_none);

    // Power-on defaults, then one capture of the programmed values after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pending <= 1'b1;
        end else if (otp_load) begin
            load_pending <= 1'b0;
        end
    end

    // Pin one low-dropout map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_one_ldo_map <= pin_one_ldo_map_reset;
        end else if (load_pending && otp_load) begin
            pin_one_ldo_map <= otp_pin_one_ldo_map; // RL6
        end else if (wr_lane && sel == sel_one_ldo) begin
            pin_one_ldo_map <= pwdata[7:0]; // RL1 RL7
        end
    end

    // Pin one converter map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_one_converter_map <= pin_one_converter_map_reset;
        end else if (load_pending && otp_load) begin
            pin_one_converter_map <= otp_pin_one_converter_map & converter_writable_mask; // RL6
        end else if (wr_lane && sel == sel_one_converter) begin
            pin_one_converter_map <= pwdata[7:0] & converter_writable_mask; // RL2 RL5 RL7
        end
    end

    // Pin two low-dropout map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_two_ldo_map <= pin_two_ldo_map_reset;
        end else if (load_pending && otp_load) begin
            pin_two_ldo_map <= otp_pin_two_ldo_map; // RL6
        end else if (wr_lane && sel == sel_two_ldo) begin
            pin_two_ldo_map <= pwdata[7:0]; // RL3 RL7
        end
    end

    // Pin two converter map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_two_converter_map <= pin_two_converter_map_reset;
        end else if (load_pending && otp_load) begin
            pin_two_converter_map <= otp_pin_two_converter_map & converter_writable_mask; // RL6
        end else if (wr_lane && sel == sel_two_converter) begin
            pin_two_converter_map <= pwdata[7:0] & converter_writable_mask; // RL4 RL5 RL7
        end
    end

    // Read data register, updated in the setup cycle of a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= read_zero;
        end else if (psel && !penable && !pwrite) begin
            unique case (sel)
                sel_one_ldo: prdata <= {24'h00_0000, pin_one_ldo_map}; // RL7
                sel_one_converter: prdata <= {24'h00_0000,
                    pin_one_converter_map & converter_writable_mask}; // RL5
                sel_two_ldo: prdata <= {24'h00_0000, pin_two_ldo_map}; // RL7
                sel_two_converter: prdata <= {24'h00_0000,
                    pin_two_converter_map & converter_writable_mask}; // RL5
                sel_none: prdata <= read_zero;
            endcase
        end
    end

    // ==================================================
    // Regulator enable combination
    pin_enable_combine u_combine (
        .pclk(pclk),
        .presetn(presetn),
        .enable_pin_one(enable_pin_one),
        .enable_pin_two(enable_pin_two),
        .pin_one_ldo_map(pin_one_ldo_map),
        .pin_one_converter_map(pin_one_converter_map),
        .pin_two_ldo_map(pin_two_ldo_map),
        .pin_two_converter_map(pin_two_converter_map),
        .ldo_other_enable(ldo_other_enable),
        .buck_other_enable(buck_other_enable),
        .ldo_enable(ldo_enable),
        .buck_enable(buck_enable)
    ); // RL8

endmodule : enable_pin_regulator_map

/* File: sim/enable_pin_driver.sv */
`timescale 1ns/1ps
// Model of the controller that drives the two enable pins
module enable_pin_driver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic request_one,
    input wire logic request_two,
    output logic enable_pin_one,
    output logic enable_pin_two
);
    // ==========
    // Pin drive
    // Levels move just after an edge, as a synchronous source would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_pin_one <= 1'b0;
            enable_pin_two <= 1'b0;
        end else begin
            enable_pin_one <= request_one;
            enable_pin_two <= request_two;
        end
    end
endmodule : enable_pin_driver

/* File: sim/map_checker_sva.sv */
`timescale 1ns/1ps
// Checker of bus answers and enable outputs of the mapping bank
module map_checker
    import enable_map_pkg::*;
(
    input logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input logic enable_pin_one, enable_pin_two,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic [ldo_count-1:0] ldo_other_enable, ldo_enable,
    input logic [buck_count-1:0] buck_other_enable, buck_enable
);
    // ==========
    // Bus phases
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_s; psel && penable; endsequence
    sequence read_s; psel && !penable && !pwrite ##1 access_s; endsequence
    // ==========
    // Assertions
    AST_PREADY_HIGH: assert property (pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (pslverr |-> access_s)
        else $error("pslverr outside access");
    AST_MAPPED_OK: assert property (access_s and paddr == 12'h0c4 |-> !pslverr)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_CONV_RESERVED_BITS: assert property (paddr == 12'h0c8 ##0 read_s |-> !prdata[7] && !prdata[6])
        else $error("reserved bits set");
    AST_READ_HOLD: assert property (read_s |=> $stable(prdata))
        else $error("read data moved");
    AST_OTHER_OR: assert property (##1 1'b1 |-> (ldo_enable & $past(ldo_other_enable))
        == $past(ldo_other_enable))
        else $error("other ldo source lost");
    AST_PINS_IDLE: assert property (!enable_pin_one && !enable_pin_two |=>
        buck_enable == $past(buck_other_enable))
        else $error("buck enable without source");
endmodule : map_checker

bind enable_pin_regulator_map map_checker u_map_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .enable_pin_one(enable_pin_one), .enable_pin_two(enable_pin_two), .paddr(paddr),
    .prdata(prdata), .ldo_other_enable(ldo_other_enable), .ldo_enable(ldo_enable),
    .buck_other_enable(buck_other_enable), .buck_enable(buck_enable));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
// Testbench of the enable pin mapping bank
module tb_top import enable_map_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, otp_load, r1, r2, p1, p2;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [7:0] otp [4];
    logic [9:0] lo, le;
    logic [3:0] bo, be;
    int fails, comparisons;
    localparam logic [7:0] dflt [4] = '{pin_one_ldo_map_reset, pin_one_converter_map_reset,
        pin_two_ldo_map_reset, pin_two_converter_map_reset};
    // Clock of 20 ns period
    always #10 pclk = ~pclk;
    enable_pin_regulator_map DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .otp_pin_one_ldo_map(otp[0]),
        .otp_pin_one_converter_map(otp[1]), .otp_pin_two_ldo_map(otp[2]),
        .otp_pin_two_converter_map(otp[3]), .otp_load(otp_load), .enable_pin_one(p1),
        .enable_pin_two(p2), .ldo_other_enable(lo), .buck_other_enable(bo),
        .ldo_enable(le), .buck_enable(be));
    enable_pin_driver u_pins (.pclk(pclk), .presetn(presetn), .request_one(r1),
        .request_two(r2), .enable_pin_one(p1), .enable_pin_two(p2));
    function automatic logic [11:0] addr(input int i);
        return 12'(pin_one_ldo_map_index + i) << index_shift;
    endfunction : addr
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // Bus cycle: setup, access until pready, then release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rw(input int i, input logic [7:0] v, input logic [7:0] x);
        apb(1'b1, addr(i), 32'(v));
        apb(1'b0, addr(i), 32'h0);
        chk("map", q, 32'(x));
    endtask : rw
    task pins(input logic a, b, input logic [9:0] l, el, input logic [3:0] k, eb);
        r1 <= a;
        r2 <= b;
        lo <= l;
        bo <= k;
        repeat (3) @(posedge pclk);
        chk("ldo", 32'(le), 32'(el));
        chk("buck", 32'(be), 32'(eb));
    endtask : pins
    task conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    initial begin
        {pclk, presetn, psel, penable, pwrite, otp_load, r1, r2} = 8'h00;
        {paddr, pwdata, lo, bo, pstrb} = {12'h000, 32'h0, 10'h000, 4'h0, 4'hf};
        otp = '{8'ha5, 8'hff, 8'h5a, 8'hc3};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) rw(i, 8'hff, i % 2 ? 8'h3f : 8'hff);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, addr(i), 32'h0);
            chk("default", q, 32'(dflt[i]));
        end
        otp_load <= 1'b1;
        @(posedge pclk);
        otp_load <= 1'b0;
        apb(1'b0, addr(0), 32'h0);
        chk("loaded", q, 32'h0000_00a5);
        apb(1'b0, addr(3), 32'h0);
        chk("loaded", q, 32'h0000_0003);
        rw(1, 8'hc4, 8'h04);
        rw(3, 8'h00, 8'h00);
        rw(2, 8'h5a, 8'h5a);
        $display("reset and access tests done");
        apb(1'b1, 12'h0bd, 32'h0000_0011);
        chk("error", 32'(e), 32'h1);
        apb(1'b0, 12'h0cc, 32'h0);
        chk("unmapped", q, 32'h0);
        rw(0, 8'h81, 8'h81);
        // A second load strobe after the first must be ignored
        otp_load <= 1'b1;
        @(posedge pclk);
        otp_load <= 1'b0;
        apb(1'b0, addr(0), 32'h0);
        chk("reload", q, 32'h0000_0081);
        rw(1, 8'h06, 8'h06);
        rw(3, 8'h20, 8'h20);
        rw(2, 8'h00, 8'h00);
        pins(1'b1, 1'b0, 10'h000, 10'h281, 4'h0, 4'h1);
        pins(1'b0, 1'b1, 10'h000, 10'h000, 4'h0, 4'h8);
        pins(1'b1, 1'b1, 10'h100, 10'h381, 4'h2, 4'hb);
        $display("pin mapping tests done");
        conclude();
    end
    // Watchdog against a hung bus cycle
    initial begin
        repeat (3000) @(posedge pclk);
        fails++;
        conclude();
    end
endmodule : tb_top
